/* File: core/timer_channel_defines.vh */
// constants for the sixteen bit timer channel and its apb register file
// assumes inclusion by bare name from core design files
`ifndef TIMER_CHANNEL_DEFINES_VH
`define TIMER_CHANNEL_DEFINES_VH

// register byte offsets
`define OFS_CONFIG      12'h000
`define OFS_MODE        12'h004
`define OFS_CONTROL     12'h00C
`define OFS_MASK        12'h018
`define OFS_RAW_STATUS  12'h01C
`define OFS_MASKED      12'h020
`define OFS_CLEAR       12'h024
`define OFS_LOAD        12'h028
`define OFS_MATCH       12'h030
`define OFS_PRESCALE    12'h038
`define OFS_VALUE       12'h048

// configuration value for split 16-bit operation
`define CFG_SPLIT_16    3'h4

// timer mode field encodings
`define MODE_ONE_SHOT   2'h1
`define MODE_PERIODIC   2'h2
`define MODE_CAPTURE    2'h3

// mode register bit positions
`define MODE_CAP_BIT    2
`define MODE_ALT_BIT    3

// control register bit positions
`define CTL_EN_BIT      0
`define CTL_STALL_BIT   1
`define CTL_EDGE_LO     2
`define CTL_EDGE_HI     3
`define CTL_TRIG_BIT    5
`define CTL_INV_BIT     6

// edge select encodings
`define EDGE_RISE       2'h0
`define EDGE_FALL       2'h1
`define EDGE_BOTH       2'h3

// status bit positions
`define ST_TIMEOUT      0
`define ST_MATCH        1
`define ST_CAPTURE      2

// reset values
`define RST_LOAD        16'hFFFF
`define RST_PRESCALE    8'h00

`endif

/* File: core/edge_detector.v */
// synchroniser and edge detector for the capture pin
// assumes the pin holds each level at least two clock periods
`timescale 1ns/100ps
`default_nettype none

module edge_detector (
	// clock and reset
	input  wire       clk,
	input  wire       sys_rst,
	// raw pin
	input  wire       pin,
	// edge pulses, one cycle each
	output reg        rise,
	output reg        fall
);

	reg sync_a;
	reg sync_b;
	reg last;

	// two-stage synchroniser, then a history flop for edges
	always @(posedge clk) begin
		if (sys_rst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			last   <= 1'b0;
			rise   <= 1'b0;
			fall   <= 1'b0;
		end else begin
			sync_a <= pin;
			sync_b <= sync_a;
			last   <= sync_b;
			rise   <= sync_b & ~last; // see [R26]
			fall   <= ~sync_b & last; // see [R26]
		end
	end

endmodule
`default_nettype wire

/* File: core/timer_channel.v */
// one sixteen bit timer channel with an apb register file
// assumes apb master on clk; capture pin driven by an outside source
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "timer_channel_defines.vh"

////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// [R1] config value 0x4 enables split 16-bit mode
// [R2] down-counter with optional 8-bit prescaler
// [R3] mode field picks one-shot or periodic
// [R4] count from load, reload after zero
// [R5] one-shot clears enable; periodic keeps counting
// [R6] timeout sets sticky raw, masked, interrupt
// [R7] trigger on timeout only if enabled
// [R8] load rewrite taken next cycle
// [R9] stall input freezes counter when enabled
// [R10] pin holds level two clocks per edge
// [R11] prescaler only in one-shot and periodic
// [R12] capture bit zero counts selected edges
// [R13] software sets load minus match edges
// [R14] each edge decrements; match sets flags
// [R15] after match reload, clear enable, ignore
// [R16] edge time: free-running, one edge kind
// [R17] capture copies count, sets event flag
// [R18] edge time runs on, reloads at zero
// [R19] capture held until next selected edge
// [R20] pwm: alt one, cap zero, mode two
// [R21] pwm reloads after zero, no flags
// [R22] pwm set at load, clear at match
// [R23] mode codes 1 one-shot 2 periodic 3 capture
// [R24] counter and load reset 0xFFFF, prescale 0
// [R25] prescale p decrements every p+1 cycles
// [R26] pin synchronised before edge detection
module timer_channel (
	// clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// system signals
	input  wire        stall,
	input  wire        capture_pin,
	output reg         irq,
	output reg         trigger,
	output reg         pwm_out
);

	////////////////////////////////////////////////////////////////////////
	// registers

	reg  [2:0]  configuration_register;
	reg  [3:0]  timer_mode_register;
	reg  [6:0]  control_register;
	reg  [2:0]  interrupt_mask_register;
	reg  [2:0]  raw_status_register;
	reg  [15:0] interval_load_register;
	reg  [15:0] match_register;
	reg  [7:0]  prescale_register;
	reg  [15:0] timer_value_register;
	reg  [15:0] count;
	reg  [7:0]  pre_count;
	reg         pwm_level;
	reg         load_pending;

	wire        rise;
	wire        fall;

	// field views
	wire [1:0] timer_mode_field  = timer_mode_register[1:0];
	wire       capture_mode_bit  = timer_mode_register[`MODE_CAP_BIT];
	wire       alt_mode          = timer_mode_register[`MODE_ALT_BIT];
	wire       count_enable_bit  = control_register[`CTL_EN_BIT];
	wire       stall_enable_bit  = control_register[`CTL_STALL_BIT];
	wire [1:0] edge_select       =
		control_register[`CTL_EDGE_HI:`CTL_EDGE_LO];
	wire       output_trigger_enable = control_register[`CTL_TRIG_BIT];
	wire       pwm_invert_bit    = control_register[`CTL_INV_BIT];

	// mode decode
	wire split_mode = (configuration_register == `CFG_SPLIT_16); // see [R1]
	wire pwm_mode   = split_mode & alt_mode & ~capture_mode_bit &
		(timer_mode_field == `MODE_PERIODIC); // see [R20]
	wire timed_mode = split_mode & ~alt_mode &
		((timer_mode_field == `MODE_ONE_SHOT) |
		 (timer_mode_field == `MODE_PERIODIC)); // see [R3] [R23]
	wire cap_mode   = split_mode & ~alt_mode &
		(timer_mode_field == `MODE_CAPTURE); // see [R23]
	wire count_mode = cap_mode & ~capture_mode_bit; // see [R12]
	wire time_mode  = cap_mode & capture_mode_bit;  // see [R16]

	////////////////////////////////////////////////////////////////////////
	// edge selection

	edge_detector u_edge (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     (capture_pin),
		.rise    (rise),
		.fall    (fall)
	);

	// edge time mode never takes both edges
	wire sel_edge = (edge_select == `EDGE_RISE) ? rise :
		(edge_select == `EDGE_FALL) ? fall :
		(edge_select == `EDGE_BOTH) ? (time_mode ? rise : rise | fall) :
		1'b0; // see [R12] [R16]

	////////////////////////////////////////////////////////////////////////
	// apb decode

	wire acc   = psel & penable & pready;
	wire wr    = acc & pwrite;
	wire setup = psel & ~penable;
	wire wr_config  = wr & (paddr == `OFS_CONFIG);
	wire wr_mode    = wr & (paddr == `OFS_MODE);
	wire wr_control = wr & (paddr == `OFS_CONTROL);
	wire wr_mask    = wr & (paddr == `OFS_MASK);
	wire wr_clear   = wr & (paddr == `OFS_CLEAR);
	wire wr_load    = wr & (paddr == `OFS_LOAD);
	wire wr_match   = wr & (paddr == `OFS_MATCH);
	wire wr_pre     = wr & (paddr == `OFS_PRESCALE);

	reg        mapped;
	reg [31:0] read_word;

	// read multiplexer and address map
	always @* begin
		mapped    = 1'b1;
		read_word = 32'h0000_0000;
		case (paddr)
		`OFS_CONFIG:     read_word = {29'h0, configuration_register};
		`OFS_MODE:       read_word = {28'h0, timer_mode_register};
		`OFS_CONTROL:    read_word = {25'h0, control_register};
		`OFS_MASK:       read_word = {29'h0, interrupt_mask_register};
		`OFS_RAW_STATUS: read_word = {29'h0, raw_status_register};
		`OFS_MASKED:     read_word = {29'h0,
			raw_status_register & interrupt_mask_register};
		`OFS_CLEAR:      read_word = 32'h0000_0000;
		`OFS_LOAD:       read_word = {16'h0, interval_load_register};
		`OFS_MATCH:      read_word = {16'h0, match_register};
		`OFS_PRESCALE:   read_word = {24'h0, prescale_register};
		`OFS_VALUE:      read_word = {16'h0, time_mode ?
			timer_value_register : count};
		default:         mapped = 1'b0;
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always @(posedge clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (psel & penable & ~pready & ~pwrite)
				prdata <= read_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counter engine

	wire frozen  = stall_enable_bit & stall; // see [R9]
	wire run     = count_enable_bit & (timed_mode | pwm_mode | time_mode);
	wire use_pre = timed_mode; // see [R11]
	wire tick    = run & ~frozen & (~use_pre | (pre_count == 8'h00));
	wire at_zero = (count == 16'h0000);
	wire timeout = tick & at_zero & (timed_mode | time_mode);
	wire edge_hit = count_enable_bit & count_mode & ~frozen & sel_edge;
	wire match_hit = edge_hit & ((count - 16'h0001) == match_register);
	wire one_shot_done = timeout & timed_mode &
		(timer_mode_field == `MODE_ONE_SHOT);
	wire capture_hit = count_enable_bit & time_mode & sel_edge;

	// count and prescale counters
	always @(posedge clk) begin
		if (sys_rst) begin
			count        <= `RST_LOAD;     // see [R24]
			pre_count    <= `RST_PRESCALE; // see [R24]
			load_pending <= 1'b0;
		end else if (load_pending) begin
			count        <= interval_load_register; // see [R8]
			pre_count    <= prescale_register;
			load_pending <= 1'b0;
		end else if (wr_load) begin
			load_pending <= 1'b1; // see [R8]
		end else if (match_hit) begin
			count <= interval_load_register; // see [R15]
		end else if (edge_hit) begin
			count <= count - 16'h0001; // see [R14]
		end else if (run & ~frozen) begin
			if (use_pre & (pre_count != 8'h00)) begin
				pre_count <= pre_count - 8'h01; // see [R25]
			end else begin
				pre_count <= prescale_register; // see [R2] [R25]
				if (at_zero)
					count <= interval_load_register; // see [R4] [R18] [R21]
				else
					count <= count - 16'h0001; // see [R2] [R4]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software registers

	always @(posedge clk) begin
		if (sys_rst) begin
			configuration_register  <= 3'h0;
			timer_mode_register     <= 4'h0;
			control_register        <= 7'h00;
			interrupt_mask_register <= 3'h0;
			interval_load_register  <= `RST_LOAD;     // see [R24]
			match_register          <= 16'h0000;
			prescale_register       <= `RST_PRESCALE; // see [R24]
		end else begin
			if (wr_config)
				configuration_register <= pwdata[2:0];
			if (wr_mode)
				timer_mode_register <= pwdata[3:0];
			if (wr_mask)
				interrupt_mask_register <= pwdata[2:0];
			if (wr_load)
				interval_load_register <= pwdata[15:0];
			if (wr_match)
				match_register <= pwdata[15:0];
			if (wr_pre)
				prescale_register <= pwdata[7:0];
			// hardware clear of enable beats a software write
			if (one_shot_done | match_hit)
				control_register <= {wr_control ? pwdata[6:1] :
					control_register[6:1], 1'b0}; // see [R5] [R15]
			else if (wr_control)
				control_register <= pwdata[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status, capture and outputs

	wire [2:0] set_bits = {capture_hit, match_hit, timeout};
	wire [2:0] clr_bits = wr_clear ? pwdata[2:0] : 3'h0;

	always @(posedge clk) begin
		if (sys_rst) begin
			raw_status_register  <= 3'h0;
			timer_value_register <= `RST_LOAD;
			irq       <= 1'b0;
			trigger   <= 1'b0;
			pwm_level <= 1'b0;
			pwm_out   <= 1'b0;
		end else begin
			// set wins over clear; pwm sets nothing
			raw_status_register <= (raw_status_register & ~clr_bits) |
				set_bits; // see [R6] [R14] [R17] [R21]
			if (capture_hit)
				timer_value_register <= count; // see [R17] [R19]
			irq <= |(((raw_status_register & ~clr_bits) | set_bits) &
				interrupt_mask_register); // see [R6]
			trigger <= timeout & output_trigger_enable; // see [R7]
			if (~pwm_mode | ~count_enable_bit)
				pwm_level <= 1'b0;
			else if (count == interval_load_register)
				pwm_level <= 1'b1; // see [R22]
			else if (count == match_register)
				pwm_level <= 1'b0; // see [R22]
			pwm_out <= pwm_level ^ pwm_invert_bit; // see [R22]
		end
	end

endmodule
`default_nettype wire

/* File: tb/timer_channel_asserts.sv */
// port checker for the timer channel
// assumes a bind into timer_channel, one clock domain
`timescale 1ns/100ps
`default_nettype none

module timer_channel_asserts (
	// clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// system
	input wire logic        stall,
	input wire logic        capture_pin,
	input wire logic        irq,
	input wire logic        trigger,
	input wire logic        pwm_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// apb answer timing
	chk_ready_wait: assert property ($rose(penable) |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_err_zero: assert property (pready && pslverr && !pwrite |->
		prdata == 32'h0) else $error("unmapped read not zero");
	// timer outputs
	chk_trig_pulse: assert property (trigger |=> !trigger)
		else $error("trigger longer than one cycle");
	chk_reset_quiet: assert property ($fell(sys_rst) |->
		!irq && !trigger && !pwm_out && !pready) else $error("busy at reset");
	chk_irq_clear: assert property ($fell(irq) |->
		$past(pready && pwrite) || $past(pready && pwrite, 2))
		else $error("irq fell without a write");
endmodule

bind timer_channel timer_channel_asserts chk_i (
	.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .stall(stall),
	.capture_pin(capture_pin), .irq(irq), .trigger(trigger),
	.pwm_out(pwm_out));
`default_nettype wire

/* File: tb/pin_source.sv */
// outside source driving the capture pin
// assumes run is changed just after a rising clk edge
`timescale 1ns/100ps
`default_nettype none

module pin_source (
	// clock
	input wire logic clk,
	// control
	input wire logic run,
	// pin
	output var logic pin
);
	logic [1:0] cnt;
	initial begin
		pin = 1'b0;
		cnt = 2'h0;
	end
	// toggle every third cycle while running
	always @(posedge clk) begin
		if (run) begin
			cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
			if (cnt == 2'h2)
				pin <= ~pin;
		end else
			cnt <= 2'h0;
	end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the timer channel
// assumes core include path and the pin source model
`timescale 1ns/100ps
`default_nettype none
`include "timer_channel_defines.vh"

module testbench;
	logic        clk, sys_rst, psel, penable, pwrite, stall, run, er, hold;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic        pready, pslverr, irq, trigger, pwm_out, pin;
	int          failures, checks, n, p, ld;

	// design and pin source
	timer_channel uut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .stall(stall),
		.capture_pin(pin), .irq(irq), .trigger(trigger), .pwm_out(pwm_out));
	pin_source src (.clk(clk), .run(run), .pin(pin));

	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// stall noise, forced high while hold is set
	always @(posedge clk) stall <= hold | 1'($urandom);

	task end_sim;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			failures++;
			end_sim;
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	// wait for a trigger pulse, cycles in n
	task wt;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (trigger !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			failures++;
			end_sim;
		end
	endtask

	// main sequence
	initial begin
		{psel, penable, pwrite, run, stall, hold} = 6'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		sys_rst = 1'b1;
		failures = 0;
		checks = 0;
		void'($urandom(18));
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		rdc(`OFS_LOAD, 32'h0000FFFF);
		rdc(`OFS_VALUE, 32'h0000FFFF);
		rdc(`OFS_PRESCALE, 32'h0);
		rdc(12'h100, 32'h0);
		chk({31'h0, er}, 32'h1);
		wr(`OFS_CONFIG, 32'h4);
		wr(`OFS_MASK, 32'h1);
		// one-shot then periodic, random prescale and load
		for (int m = 1; m <= 2; m++) begin
			p = $urandom % 4;
			ld = 3 + $urandom % 8;
			wr(`OFS_CONTROL, 32'h0);
			wr(`OFS_MODE, 32'(m));
			wr(`OFS_PRESCALE, 32'(p));
			wr(`OFS_LOAD, 32'(ld));
			wr(`OFS_CONTROL, 32'h21);
			wt;
			if (m == 2) begin
				wt;
				chk(32'(n), 32'((ld + 1) * (p + 1)));
			end
			rdc(`OFS_RAW_STATUS, 32'h1);
			chk({31'h0, irq}, 32'h1);
			rdc(`OFS_CONTROL, (m == 2) ? 32'h21 : 32'h20);
		end
		// stall: frozen while held, moves once released
		wr(`OFS_CONTROL, 32'h0);
		hold <= 1'b1;
		wr(`OFS_LOAD, 32'h100);
		wr(`OFS_CONTROL, 32'h3);
		repeat (10) @(posedge clk);
		rdc(`OFS_VALUE, 32'h100);
		hold <= 1'b0;
		repeat (40) @(posedge clk);
		apb(1'b0, `OFS_VALUE, 32'h0);
		chk({31'h0, rd < 32'h100}, 32'h1);
		wr(`OFS_CONTROL, 32'h0);
		wr(`OFS_CLEAR, 32'h1);
		rdc(`OFS_RAW_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// edge count: rise, fall, both over six pin edges
		wr(`OFS_MODE, 32'h3);
		wr(`OFS_MATCH, 32'h6);
		for (int e = 0; e < 4; e++) if (e != 2) begin
			wr(`OFS_CONTROL, 32'h0);
			wr(`OFS_LOAD, 32'hA);
			wr(`OFS_CLEAR, 32'h7);
			wr(`OFS_CONTROL, 32'(e << 2) | 32'h1);
			run <= 1'b1;
			repeat (18) @(posedge clk);
			run <= 1'b0;
			repeat (10) @(posedge clk);
			rdc(`OFS_VALUE, (e == 3) ? 32'hA : 32'h7);
			rdc(`OFS_RAW_STATUS, (e == 3) ? 32'h2 : 32'h0);
			rdc(`OFS_CONTROL, 32'(e << 2) | ((e == 3) ? 0 : 1));
		end
		// edge time capture
		wr(`OFS_CONTROL, 32'h0);
		wr(`OFS_MODE, 32'h7);
		wr(`OFS_LOAD, 32'h1000);
		wr(`OFS_CLEAR, 32'h7);
		wr(`OFS_CONTROL, 32'h1);
		run <= 1'b1;
		repeat (6) @(posedge clk);
		run <= 1'b0;
		repeat (10) @(posedge clk);
		rdc(`OFS_RAW_STATUS, 32'h4);
		apb(1'b0, `OFS_VALUE, 32'h0);
		v = rd;
		chk({31'h0, v < 32'h1000}, 32'h1);
		repeat (20) @(posedge clk);
		rdc(`OFS_VALUE, v);
		// pwm duty, plain then inverted
		wr(`OFS_CONTROL, 32'h0);
		wr(`OFS_CLEAR, 32'h7);
		wr(`OFS_MODE, 32'hA);
		wr(`OFS_LOAD, 32'h9);
		wr(`OFS_MATCH, 32'h3);
		for (int i = 0; i < 2; i++) begin
			wr(`OFS_CONTROL, i ? 32'h41 : 32'h1);
			repeat (30) @(posedge clk);
			n = 0;
			repeat (100) begin
				@(posedge clk);
				if (pwm_out === 1'b1)
					n++;
			end
			chk(32'(n), i ? 32'd40 : 32'd60);
		end
		rdc(`OFS_RAW_STATUS, 32'h0);
		end_sim;
	end
endmodule
`default_nettype wire
